// ==== core/ltx_pkg.sv ====
// Package for the per-channel transmit path configuration registers
package ltx_pkg;

   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned NUM_CH = 2;

   // Register offsets
   localparam logic [7:0] OFS_TX_CONFIG_A_CH1 = 8'h04;
   localparam logic [7:0] OFS_TX_CONFIG_B_CH1 = 8'h05;
   localparam logic [7:0] OFS_TX_CONFIG_A_CH2 = 8'h24;
   localparam logic [7:0] OFS_TX_CONFIG_B_CH2 = 8'h25;
   localparam logic [7:0] OFS_CH_STRIDE       = 8'h20;

   // Field positions, register A
   localparam int unsigned A_TX_OFF_BIT  = 4;
   localparam int unsigned A_INVERT_BIT  = 3;
   localparam int unsigned A_EDGE_BIT    = 2;
   localparam int unsigned A_MODE_LSB    = 0;
   localparam logic [7:0]  A_DEFINED_MSK = 8'h1F;

   // Field positions, register B
   localparam int unsigned B_DRIVER_FAILURE_MONITOR_DISABLE_BIT = 5;
   localparam int unsigned B_HIZ_BIT     = 4;
   localparam int unsigned B_PULSE_LSB   = 0;
   localparam logic [7:0]  B_DEFINED_MSK = 8'h3F;

   // Reset values
   localparam logic [7:0] A_RESET = 8'h00;
   localparam logic [7:0] B_RESET = 8'h10;

   // Mode field codes
   localparam logic [1:0] MODE_HDB3_B8ZS = 2'h0;
   localparam logic [1:0] MODE_AMI       = 2'h1;

   // Pulse template codes
   localparam logic [3:0] PULSE_E1_LAST     = 4'h1;
   localparam logic [3:0] PULSE_DSX1_LAST   = 4'h6;
   localparam logic [3:0] PULSE_J1          = 4'h7;
   localparam logic [3:0] PULSE_DS1_FIRST   = 4'h8;
   localparam logic [3:0] PULSE_DS1_LAST    = 4'hB;

   typedef enum logic [1:0] {
      LTX_ENC_HDB3_B8ZS,
      LTX_ENC_AMI,
      LTX_ENC_BYPASS
   } ltx_encoder_e;

   typedef enum logic [2:0] {
      LTX_TPL_E1,
      LTX_TPL_DSX1,
      LTX_TPL_J1,
      LTX_TPL_DS1_LBO,
      LTX_TPL_USER
   } ltx_template_e;

   // Register bus request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } ltx_bus_req_s;

   // Decoded per-channel controls
   typedef struct packed {
      logic          tx_power_down;
      logic          driver_enable;
      logic          transmit_data_invert;
      logic          transmit_clock_edge_select;
      logic          single_rail_select;
      ltx_encoder_e  encoder;
      logic          driver_failure_monitor_enable;
      ltx_template_e template_class;
      logic [1:0]    ds1_build_out;
      logic [3:0]    pulse_template_select;
   } ltx_ch_ctrl_s;

endpackage : ltx_pkg

// ==== core/ltx_tx_config.sv ====
// Transmit path configuration registers for both line channels
//
// Function
// - Each channel has both registers; channel two sits 0x20 above channel one.
// - Power-down bit set stops transmitter and floats its line driver.
// - Invert bit zero: transmit data active high; one: active low.
// - Edge bit zero samples dual rail on falling clock; one on rising.
// - Mode 00 enables HDB3/B8ZS encoder and shaper, single rail data.
// - Mode 01 enables AMI encoder and shaper, single rail data.
// - Mode 1x bypasses encoder, dual rail data on positive/negative pins.
// - Monitor disable bit zero keeps driver failure monitor on; one turns off.
// - High impedance bit, reset one, floats only the driver.
// - Template field selects E1, DSX1, J1, DS1 build-out or user waveform.
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps

module ltx_tx_config
   import ltx_pkg::*;
(
   // Clock and reset
   input  wire logic                       clk_i,
   input  wire logic                       resetn_i,
   // Register port
   input  wire ltx_pkg::ltx_bus_req_s      bus_req_i,
   output logic [ltx_pkg::DATA_W-1:0]      bus_rdata_o,
   // Per-channel decoded controls
   output ltx_pkg::ltx_ch_ctrl_s           ch_ctrl_o [ltx_pkg::NUM_CH]
);
   import ltx_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State

   // Only the defined bits of each register are kept: reserved positions are
   // masked on write, so the stored copy is exactly what software reads back
   // and what the control decode sees
   typedef struct packed {
      logic [NUM_CH-1:0][DATA_W-1:0] cfg_a;
      logic [NUM_CH-1:0][DATA_W-1:0] cfg_b;
      logic [DATA_W-1:0]             rdata;
   } ltx_state_s;

   ltx_state_s state_q;
   ltx_state_s state_d;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode

   logic [NUM_CH-1:0] hit_a;
   logic [NUM_CH-1:0] hit_b;

   always_comb
   begin
      // Each register answers at one offset only; channel two repeats the
      // map one stride higher
      hit_a[0] = (bus_req_i.addr == OFS_TX_CONFIG_A_CH1);
      hit_b[0] = (bus_req_i.addr == OFS_TX_CONFIG_B_CH1);
      hit_a[1] = (bus_req_i.addr == OFS_TX_CONFIG_A_CH2);
      hit_b[1] = (bus_req_i.addr == OFS_TX_CONFIG_B_CH2);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Access qualifiers

   // A strobe acts only on the register whose offset it matches; write and
   // read strobes never come together, so neither needs priority
   logic [NUM_CH-1:0] wr_a;
   logic [NUM_CH-1:0] wr_b;
   logic [NUM_CH-1:0] rd_a;
   logic [NUM_CH-1:0] rd_b;

   always_comb
   begin
      for (int c = 0; c < NUM_CH; c++)
      begin
         wr_a[c] = bus_req_i.wr && hit_a[c];
         wr_b[c] = bus_req_i.wr && hit_b[c];
         rd_a[c] = bus_req_i.rd && hit_a[c];
         rd_b[c] = bus_req_i.rd && hit_b[c];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Next state

   always_comb
   begin
      state_d = state_q;

      // Write path: reserved bits are never stored, so they read zero
      for (int c = 0; c < NUM_CH; c++)
      begin
         if (wr_a[c])
         begin
            state_d.cfg_a[c] = bus_req_i.wdata & A_DEFINED_MSK;
         end
         // Top bits of B are dropped even if software breaks the zero convention
         if (wr_b[c])
         begin
            state_d.cfg_b[c] = bus_req_i.wdata & B_DEFINED_MSK;
         end
      end

      // Read path: data stands in the cycle after the strobe only and is zero
      // otherwise, which also covers unmapped offsets
      state_d.rdata = '0;
      for (int c = 0; c < NUM_CH; c++)
      begin
         if (rd_a[c])
         begin
            state_d.rdata = state_q.cfg_a[c];
         end
         if (rd_b[c])
         begin
            state_d.rdata = state_q.cfg_b[c];
         end
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         // Every channel leaves reset powered up but with its driver floated
         for (int c = 0; c < NUM_CH; c++)
         begin
            state_q.cfg_a[c] <= A_RESET;
            state_q.cfg_b[c] <= B_RESET;
         end
         state_q.rdata <= '0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data

   // Registered, so the bus sees a settled value for the whole cycle
   assign bus_rdata_o = state_q.rdata;

   ////////////////////////////////////////////////////////////////////////////
   // Control decode, one copy per channel
   //
   // The controls are plain levels taken straight from the stored fields, so a
   // write reaches the transmit path right after the edge that stores it.
   // Nothing is registered a second time: each channel stays in step with its
   // own register copy and no extra flip-flops are spent.

   for (genvar c = 0; c < NUM_CH; c++)
   begin : g_ch

      // Stored copies of this channel's two registers
      logic [DATA_W-1:0] cfg_a;
      logic [DATA_W-1:0] cfg_b;

      // Raw fields
      logic              pd_bit;
      logic              invert_bit;
      logic              edge_bit;
      logic [1:0]        mode;
      logic              driver_failure_monitor_disable_bit;
      logic              hiz_bit;
      logic [3:0]        pulse;

      // Template class flags, at most one high; none means the user waveform
      logic              tpl_e1;
      logic              tpl_dsx1;
      logic              tpl_j1;
      logic              tpl_ds1;

      // Decoded selections
      ltx_encoder_e      encoder;
      logic              single_rail;
      ltx_template_e     template_class;
      logic              driver_on;
      logic              monitor_on;

      // Assembled control word
      ltx_ch_ctrl_s      ctrl;

      ////////////////////////////////////////////////////////////////////////
      // Field extraction

      assign cfg_a       = state_q.cfg_a[c];
      assign cfg_b       = state_q.cfg_b[c];
      assign pd_bit      = cfg_a[A_TX_OFF_BIT];
      assign mode        = cfg_a[A_MODE_LSB +: 2];
      assign driver_failure_monitor_disable_bit = cfg_b[B_DRIVER_FAILURE_MONITOR_DISABLE_BIT];
      assign hiz_bit     = cfg_b[B_HIZ_BIT];
      assign pulse       = cfg_b[B_PULSE_LSB +: 4];

      ////////////////////////////////////////////////////////////////////////
      // Data polarity and sampling edge

      // Polarity applies to whichever rail format the mode selects; the edge
      // only matters for dual rail input, which is sampled directly
      assign invert_bit  = cfg_a[A_INVERT_BIT];
      assign edge_bit    = cfg_a[A_EDGE_BIT];

      ////////////////////////////////////////////////////////////////////////
      // Line driver

      // Either power-down or high impedance floats the driver; only
      // power-down stops the rest of the path, so the encoder and shaper
      // keep running while the line is merely floated
      assign driver_on = !pd_bit && !hiz_bit;

      ////////////////////////////////////////////////////////////////////////
      // Driver failure monitor

      // The stored bit disables the monitor, so reset leaves it running
      assign monitor_on = !driver_failure_monitor_disable_bit;

      ////////////////////////////////////////////////////////////////////////
      // Encoder and rail selection

      // Both codes with the upper bit set bypass the encoder; the lower bit
      // is then a don't-care and is not decoded at all
      always_comb
      begin
         if (mode == MODE_HDB3_B8ZS)
         begin
            encoder     = LTX_ENC_HDB3_B8ZS;
            single_rail = 1'b1;
         end
         else if (mode == MODE_AMI)
         begin
            encoder     = LTX_ENC_AMI;
            single_rail = 1'b1;
         end
         else
         begin
            encoder     = LTX_ENC_BYPASS;
            single_rail = 1'b0;
         end
      end

      ////////////////////////////////////////////////////////////////////////
      // Pulse template class

      assign tpl_e1   = (pulse <= PULSE_E1_LAST);
      assign tpl_dsx1 = (pulse > PULSE_E1_LAST) && (pulse <= PULSE_DSX1_LAST);
      assign tpl_j1   = (pulse == PULSE_J1);
      assign tpl_ds1  = (pulse >= PULSE_DS1_FIRST) && (pulse <= PULSE_DS1_LAST);

      // Every code above the DS1 range falls through to the user waveform
      always_comb
      begin
         if (tpl_e1)
         begin
            template_class = LTX_TPL_E1;
         end
         else if (tpl_dsx1)
         begin
            template_class = LTX_TPL_DSX1;
         end
         else if (tpl_j1)
         begin
            template_class = LTX_TPL_J1;
         end
         else if (tpl_ds1)
         begin
            template_class = LTX_TPL_DS1_LBO;
         end
         else
         begin
            template_class = LTX_TPL_USER;
         end
      end

      ////////////////////////////////////////////////////////////////////////
      // Control word

      always_comb
      begin
         ctrl                               = '0;
         ctrl.tx_power_down                 = pd_bit;
         ctrl.driver_enable                 = driver_on;
         ctrl.transmit_data_invert          = invert_bit;
         ctrl.transmit_clock_edge_select    = edge_bit;
         ctrl.single_rail_select            = single_rail;
         ctrl.encoder                       = encoder;
         ctrl.driver_failure_monitor_enable = monitor_on;
         ctrl.template_class                = template_class;
         // 0000 and 0001 both map to E1; the index tells the shaper which
         ctrl.pulse_template_select         = pulse;
         // Meaningful for the DS1 codes only; 00 is 0 dB, 11 the deepest step
         ctrl.ds1_build_out                 = pulse[1:0];
      end

      assign ch_ctrl_o[c] = ctrl;

   end : g_ch

endmodule : ltx_tx_config

// ==== verification/ltx_tx_config_asserts.sv ====
// Port checks for the transmit configuration registers
`timescale 1ns/1ps
module ltx_tx_config_asserts
   import ltx_pkg::*;
(
   // Clock and reset
   input wire logic                      clk_i,
   input wire logic                      resetn_i,
   // Register port and controls
   input wire ltx_pkg::ltx_bus_req_s     bus_req_i,
   input wire logic [ltx_pkg::DATA_W-1:0] bus_rdata_o,
   input wire ltx_pkg::ltx_ch_ctrl_s     ch_ctrl_o [ltx_pkg::NUM_CH]
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   a_rdata_idle:
      assert property (!$past(bus_req_i.rd) |-> bus_rdata_o == 8'h00)
      else $error("read data not idle");
   a_rdata_resv:
      assert property (bus_req_i.rd |=> bus_rdata_o[7:6] == 2'h0)
      else $error("reserved bits read back");
   a_pd_floats:
      assert property (ch_ctrl_o[0].tx_power_down |-> !ch_ctrl_o[0].driver_enable)
      else $error("driver on in power down");
   a_ch2_hiz:
      assert property (bus_req_i.wr && bus_req_i.addr == 8'h25 && bus_req_i.wdata[4]
         |=> !ch_ctrl_o[1].driver_enable)
      else $error("channel two driver not floated");
   a_inv_edge:
      assert property (bus_req_i.wr && bus_req_i.addr == 8'h04 |=>
         {ch_ctrl_o[0].transmit_data_invert, ch_ctrl_o[0].transmit_clock_edge_select}
         == $past(bus_req_i.wdata[3:2]))
      else $error("invert or edge not written");
   a_driver_failure_monitor_disable:
      assert property (bus_req_i.wr && bus_req_i.addr == 8'h05 |=>
         ch_ctrl_o[0].driver_failure_monitor_enable != $past(bus_req_i.wdata[5]))
      else $error("monitor enable wrong");
   a_ami_mode:
      assert property (bus_req_i.wr && bus_req_i.addr == 8'h04 && bus_req_i.wdata[1:0] == 2'h1
         |=> ch_ctrl_o[0].encoder == LTX_ENC_AMI)
      else $error("mode 01 not AMI");
   a_user_tpl:
      assert property (&ch_ctrl_o[0].pulse_template_select[3:2]
         |-> ch_ctrl_o[0].template_class == LTX_TPL_USER)
      else $error("codes 11xx not user waveform");
endmodule : ltx_tx_config_asserts
////////////////////////////////////////////////
bind ltx_tx_config ltx_tx_config_asserts u_ltx_tx_config_asserts (.clk_i(clk_i),
   .resetn_i(resetn_i), .bus_req_i(bus_req_i), .bus_rdata_o(bus_rdata_o), .ch_ctrl_o(ch_ctrl_o));

// ==== verification/ltx_tx_config_tb_top.sv ====
// Self-checking bench for the transmit configuration registers
`timescale 1ns/1ps
module ltx_tx_config_tb_top;
   import ltx_pkg::*;
   logic          clk_i = 1'b0;
   logic          resetn_i = 1'b0;
   ltx_bus_req_s  bus_req_i = '0;
   logic [7:0]    bus_rdata_o;
   ltx_ch_ctrl_s  ch_ctrl_o [NUM_CH];
   int            err_count = 0;
   int            num_checks = 0;
   ltx_tx_config u_ltx_tx_config (.clk_i(clk_i), .resetn_i(resetn_i), .bus_req_i(bus_req_i),
      .bus_rdata_o(bus_rdata_o), .ch_ctrl_o(ch_ctrl_o));
   initial
   begin
      forever #2.5 clk_i = ~clk_i;
   end
   ////////////////////////////////////////////////
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      num_checks++;
      if (g !== e)
      begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // Strobe drops one edge later, so back-to-back calls never touch it twice in a step
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      bus_req_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      bus_req_i.wr <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge clk_i);
      bus_req_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      bus_req_i.rd <= 1'b0;
      #1;
      chk("rdata", e, bus_rdata_o);
   endtask : rd
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   initial
   begin
      ltx_template_e t;
      ltx_encoder_e  m;
      repeat (16) @(posedge clk_i);
      resetn_i <= 1'b1;
      rd(8'h04, 8'h00);
      rd(8'h05, 8'h10);
      rd(8'h24, 8'h00);
      rd(8'h25, 8'h10);
      chk("dfm_en", 8'h01, 8'(ch_ctrl_o[0].driver_failure_monitor_enable));
      chk("drv_en", 8'h00, 8'(ch_ctrl_o[0].driver_enable));
      wr(8'h05, 8'h00);
      chk("drv_en", 8'h01, 8'(ch_ctrl_o[0].driver_enable));
      wr(8'h04, 8'h10);
      chk("tx_pd", 8'h01, 8'(ch_ctrl_o[0].tx_power_down));
      chk("drv_en", 8'h00, 8'(ch_ctrl_o[0].driver_enable));
      wr(8'h04, 8'h00);
      wr(8'h25, 8'h00);
      chk("drv_en2", 8'h01, 8'(ch_ctrl_o[1].driver_enable));
      wr(8'h25, 8'h10);
      chk("drv_en", 8'h01, 8'(ch_ctrl_o[0].driver_enable));
      chk("drv_en2", 8'h00, 8'(ch_ctrl_o[1].driver_enable));
      wr(8'h05, 8'h3F);
      chk("dfm_en", 8'h00, 8'(ch_ctrl_o[0].driver_failure_monitor_enable));
      rd(8'h05, 8'h3F);
      wr(8'h04, 8'hFF);
      rd(8'h04, 8'h1F);
      rd(8'h24, 8'h00);
      wr(8'h06, 8'h5A);
      rd(8'h06, 8'h00);
      for (int i = 0; i < 4; i++)
      begin
         wr(8'h24, 8'(i * 5));
         m = i == 0 ? LTX_ENC_HDB3_B8ZS : i == 1 ? LTX_ENC_AMI : LTX_ENC_BYPASS;
         chk("encoder", 8'(m), 8'(ch_ctrl_o[1].encoder));
         chk("single", 8'(i < 2), 8'(ch_ctrl_o[1].single_rail_select));
         chk("invert", 8'(i / 2), 8'(ch_ctrl_o[1].transmit_data_invert));
         chk("edge", 8'(i % 2), 8'(ch_ctrl_o[1].transmit_clock_edge_select));
         wr(8'h04, 8'(i * 5));
         chk("encoder1", 8'(m), 8'(ch_ctrl_o[0].encoder));
      end
      for (int p = 0; p < 16; p++)
      begin
         wr(8'h05, 8'(p));
         t = p < 2 ? LTX_TPL_E1 : p < 7 ? LTX_TPL_DSX1 : p == 7 ? LTX_TPL_J1 :
            p < 12 ? LTX_TPL_DS1_LBO : LTX_TPL_USER;
         chk("template", 8'(t), 8'(ch_ctrl_o[0].template_class));
         chk("pulse", 8'(p), 8'(ch_ctrl_o[0].pulse_template_select));
         if (p >= 8 && p < 12)
         begin
            chk("lbo", 8'(p - 8), 8'(ch_ctrl_o[0].ds1_build_out));
         end
      end
      // Mid-run reset must bring channel one register B and channel two register A back to their defaults
      @(posedge clk_i);
      resetn_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      resetn_i <= 1'b1;
      rd(8'h05, 8'h10);
      rd(8'h24, 8'h00);
      chk("drv_en", 8'h00, 8'(ch_ctrl_o[0].driver_enable));
      chk("dfm_en", 8'h01, 8'(ch_ctrl_o[0].driver_failure_monitor_enable));
      chk("template", 8'(LTX_TPL_E1), 8'(ch_ctrl_o[0].template_class));
      give_verdict();
   end
   initial
   begin
      #20000;
      err_count++;
      give_verdict();
   end
endmodule : ltx_tx_config_tb_top
